// ### rtl/operator_panel_regs.svh
// Register offsets, field positions, reset values and timing counts of the operator panel
`ifndef OPERATOR_PANEL_REGS_SVH
`define OPERATOR_PANEL_REGS_SVH
// Register byte offsets
`define OP_CTRL_ADDR     12'h000
`define OP_STATUS_ADDR   12'h004
`define OP_DISPLAY_ADDR  12'h008
`define OP_ERRCODE_ADDR  12'h00C
`define OP_NUMBER_ADDR   12'h010
// Control register fields
`define CTRL_SPUN_UP     0
`define CTRL_AVAILABLE   1
`define CTRL_ONLINE_A    2
`define CTRL_ONLINE_B    3
`define CTRL_RW_READY    4
`define CTRL_ERR_STATUS  5
`define CTRL_FAULT_DET   6
`define CTRL_PHYS_WP     7
`define CTRL_REFUSE_WR   8
`define CTRL_WIDTH       9
`define CTRL_RESET       9'h000
// Unit number reset value and upper limit
`define UNIT_RESET       16'h0000
`define UNIT_MAX         16'h4094
// Timing, in milliseconds, and derived cycle counts at 125 MHz
`define CLK_HZ           125000000
`define SHOW_TIME_MS     2000
`define BLINK_TIME_MS    250
`define DEBOUNCE_TIME_MS 10
`define SHOW_CYCLES      (`SHOW_TIME_MS * (`CLK_HZ / 1000))
`define BLINK_CYCLES     (`BLINK_TIME_MS * (`CLK_HZ / 1000))
`define DEBOUNCE_CYCLES  (`DEBOUNCE_TIME_MS * (`CLK_HZ / 1000))
// Display character codes
`define CH_BLANK         8'h20
`define CH_A             8'h41
`define CH_B             8'h42
`define CH_E             8'h45
`define CH_R             8'h52
`define CH_T             8'h54
`define CH_W             8'h57
`define CH_ZERO          8'h30
`endif

// ### rtl/operator_panel_pkg.sv
// Types shared by the operator panel controller
package operator_panel_pkg;
  typedef enum logic [2:0] {
    MODE_NORMAL   = 3'b000,
    MODE_UNIT     = 3'b001,
    MODE_TESTNUM  = 3'b010,
    MODE_RUNNING  = 3'b011,
    MODE_FAULTSHOW = 3'b100
  } panel_mode_t;
  typedef logic [7:0] char_t;
endpackage

// ### rtl/operator_panel.sv
// Operator panel controller with APB status and control registers
//
// Functional notes
// - Port active: test press shows unit two seconds
// - Ports idle: test press latches test mode
// - Port A press selects next digit, ones first
// - Port B increments blinking digit, wraps 9/4
// - Unit number kept 0000-4094; test exits
// - First write-protect press shows test number
// - Second write-protect press blinks T, runs test
// - While running, A, test, WP stop blink
// - Switch view: R at position 3
// - Switch view: W at position 2
// - Switch view: A at position 1
// - Switch view: B at position 0
// - No switches in: show unit number
// - Fault lit: fault press shows E and code
// - LEDs driven from drive status, test mode and lamp test
// - Ready needs run lit, spun up, available/online
// - Run LED follows spun-up state
// - Fault LED lit by error bit and fault
// - Write-protect LED: physical or refused writes
// - Port LED lit while online through port
// - Test LED lit in latched test mode or lamp test
// - Idle fault press: two-second lamp test
// - Fault LED off whenever error bit clears
`include "operator_panel_regs.svh"
module operator_panel #(
  parameter int SHOW_CYCLES     = `SHOW_CYCLES,
  parameter int BLINK_CYCLES    = `BLINK_CYCLES,
  parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic [5:0]               switchIn,
  output logic                          ledReady,
  output logic                          ledRun,
  output logic                          ledFault,
  output logic                          ledWriteProt,
  output logic                          ledPortA,
  output logic                          ledPortB,
  output logic                          ledTest,
  output operator_panel_pkg::char_t     disp3,
  output operator_panel_pkg::char_t     disp2,
  output operator_panel_pkg::char_t     disp1,
  output operator_panel_pkg::char_t     disp0,
  output logic                          testRunning
);
  import operator_panel_pkg::*;

  // Counters reload with count minus one, so a count below two cannot be served
  if (SHOW_CYCLES < 2 || BLINK_CYCLES < 2 || DEBOUNCE_CYCLES < 2) begin : timingCheck
    $error("operator_panel: timing counts too small");
  end

  // Switch index: 0 run, 1 write protect, 2 port A, 3 port B, 4 test, 5 fault
  localparam int SW_RUN = 0;
  localparam int SW_WP = 1;
  localparam int SW_A = 2;
  localparam int SW_B = 3;
  localparam int SW_TEST = 4;
  localparam int SW_FAULT = 5;

  // ---------------------------------------------------------------
  // Switch synchronising and debounce
  // ---------------------------------------------------------------
  logic [5:0]  syncA;
  logic [5:0]  syncB;
  logic [5:0]  syncC;
  logic [5:0]  swLevel;
  logic [5:0]  swPrev;
  logic [5:0]  press;
  logic [31:0] bounceCount [6];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      syncA <= 6'h00;
      syncB <= 6'h00;
      syncC <= 6'h00;
    end else begin
      syncA <= switchIn;
      syncB <= syncA;
      syncC <= syncB;
    end
  end

  // Contacts bounce for milliseconds; a level counts once stable that long
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      swLevel <= 6'h00;
      for (int i = 0; i < 6; i++) begin
        bounceCount[i] <= 32'h0000_0000;
      end
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (syncB[i] != syncC[i] || syncC[i] == swLevel[i]) begin
          bounceCount[i] <= 32'h0000_0000;
        end else if (bounceCount[i] == 32'(DEBOUNCE_CYCLES - 1)) begin
          bounceCount[i] <= 32'h0000_0000;
          swLevel[i] <= syncC[i];
        end else begin
          bounceCount[i] <= bounceCount[i] + 32'h0000_0001;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      swPrev <= 6'h00;
    end else begin
      swPrev <= swLevel;
    end
  end

  assign press = swLevel & ~swPrev;

  // ---------------------------------------------------------------
  // APB registers
  // ---------------------------------------------------------------
  logic [`CTRL_WIDTH-1:0] ctrl;
  logic [7:0]             errCode;
  logic                   apbWrite;
  logic                   apbRead;
  logic                   badAddr;

  assign apbWrite = psel && penable && pwrite;
  assign apbRead = psel && penable && !pwrite;
  assign badAddr = !(paddr == `OP_CTRL_ADDR || paddr == `OP_STATUS_ADDR ||
                     paddr == `OP_DISPLAY_ADDR || paddr == `OP_ERRCODE_ADDR ||
                     paddr == `OP_NUMBER_ADDR);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl <= `CTRL_RESET;
      errCode <= 8'h00;
    end else if (apbWrite && pready) begin
      if (paddr == `OP_CTRL_ADDR) begin
        ctrl <= pwdata[`CTRL_WIDTH-1:0];
      end
      if (paddr == `OP_ERRCODE_ADDR) begin
        errCode <= pwdata[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Panel mode machine
  // ---------------------------------------------------------------
  panel_mode_t mode;
  logic [15:0] unitNum;
  logic [7:0]  testNum;
  logic [1:0]  digitSel;
  logic        editing;
  logic        portBusy;
  logic        inTest;
  logic        lampTest;
  logic        showUnit;
  logic [31:0] showCount;
  logic [31:0] blinkCount;
  logic        blinkPhase;
  logic [15:0] bumped;

  assign portBusy = ledPortA || ledPortB || swLevel[SW_A] || swLevel[SW_B];
  assign inTest = (mode == MODE_UNIT) || (mode == MODE_TESTNUM) || (mode == MODE_RUNNING);

  function automatic logic [15:0] bumpDigit(input logic [15:0] value,
                                            input logic [1:0]  sel);
    logic [3:0]  d;
    logic [3:0]  top;
    logic [15:0] result;
    d = value[sel*4 +: 4];
    top = (sel == 2'd3) ? 4'h4 : 4'h9;
    result = value;
    result[sel*4 +: 4] = (d >= top) ? 4'h0 : d + 4'h1;
    return result;
  endfunction

  assign bumped = bumpDigit(mode == MODE_UNIT ? unitNum : {8'h00, testNum}, digitSel);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode <= MODE_NORMAL;
      unitNum <= `UNIT_RESET;
      testNum <= 8'h00;
      digitSel <= 2'd0;
      editing <= 1'b0;
    end else begin
      case (mode)
        MODE_NORMAL: begin
          if (press[SW_TEST] && !portBusy) begin
            mode <= MODE_UNIT;
            editing <= 1'b0;
          end else if (press[SW_FAULT] && ledFault) begin
            mode <= MODE_FAULTSHOW;
          end
        end
        MODE_UNIT, MODE_TESTNUM: begin
          if (press[SW_TEST]) begin
            mode <= MODE_NORMAL;
            editing <= 1'b0;
            if (unitNum > `UNIT_MAX) begin
              unitNum <= `UNIT_MAX;
            end
          end else if (press[SW_A]) begin
            digitSel <= editing ? digitSel + 2'd1 : 2'd0;
            if (mode == MODE_TESTNUM && editing) begin
              digitSel <= digitSel ^ 2'd1;
            end
            editing <= 1'b1;
          end else if (press[SW_B] && editing) begin
            if (mode == MODE_UNIT) begin
              unitNum <= bumped;
            end else begin
              testNum <= bumped[7:0];
            end
          end else if (press[SW_WP]) begin
            if (mode == MODE_UNIT) begin
              mode <= MODE_TESTNUM;
              testNum <= 8'h00;
              editing <= 1'b0;
            end else begin
              mode <= MODE_RUNNING;
              editing <= 1'b0;
            end
          end
        end
        MODE_RUNNING: begin
          if (press[SW_TEST]) begin
            mode <= MODE_NORMAL;
            if (unitNum > `UNIT_MAX) begin
              unitNum <= `UNIT_MAX;
            end
          end else if (press[SW_A]) begin
            mode <= MODE_TESTNUM;
            digitSel <= 2'd0;
            editing <= 1'b1;
          end else if (press[SW_WP]) begin
            mode <= MODE_TESTNUM;
          end
        end
        MODE_FAULTSHOW: begin
          if (press[SW_FAULT] || !ledFault) begin
            mode <= MODE_NORMAL;
          end
        end
        default: begin
          mode <= MODE_NORMAL;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Timed displays and blink
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      showCount <= 32'h0000_0000;
      showUnit <= 1'b0;
      lampTest <= 1'b0;
    end else if (mode == MODE_NORMAL && press[SW_TEST] && portBusy) begin
      showCount <= 32'(SHOW_CYCLES - 1);
      showUnit <= 1'b1;
      lampTest <= 1'b0;
    end else if (mode == MODE_NORMAL && press[SW_FAULT] && !ledFault &&
                 !ledPortA && !ledPortB) begin
      showCount <= 32'(SHOW_CYCLES - 1);
      lampTest <= 1'b1;
      showUnit <= 1'b0;
    end else if (showCount != 32'h0000_0000) begin
      showCount <= showCount - 32'h0000_0001;
    end else begin
      showUnit <= 1'b0;
      lampTest <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      blinkCount <= 32'h0000_0000;
      blinkPhase <= 1'b0;
    end else if (blinkCount == 32'(BLINK_CYCLES - 1)) begin
      blinkCount <= 32'h0000_0000;
      blinkPhase <= ~blinkPhase;
    end else begin
      blinkCount <= blinkCount + 32'h0000_0001;
    end
  end

  // ---------------------------------------------------------------
  // LEDs, from drive status, test mode and lamp test
  // ---------------------------------------------------------------
  logic faultLit;
  assign faultLit = ctrl[`CTRL_ERR_STATUS] && ctrl[`CTRL_FAULT_DET];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ledRun <= 1'b0;
      ledReady <= 1'b0;
      ledFault <= 1'b0;
      ledWriteProt <= 1'b0;
      ledPortA <= 1'b0;
      ledPortB <= 1'b0;
      ledTest <= 1'b0;
    end else begin
      // Drive status and test mode; lamp test overlays the run, ready, write-protect and test lamps, not fault or port, and never feeds back into logic
      ledRun <= ctrl[`CTRL_SPUN_UP] || lampTest;
      ledReady <= (ledRun && ctrl[`CTRL_SPUN_UP] && (ctrl[`CTRL_AVAILABLE] ||
                  ((ctrl[`CTRL_ONLINE_A] || ctrl[`CTRL_ONLINE_B]) && ctrl[`CTRL_RW_READY])))
                  || lampTest;
      ledFault <= faultLit;
      ledWriteProt <= ctrl[`CTRL_PHYS_WP] || ctrl[`CTRL_REFUSE_WR] || lampTest;
      ledPortA <= ctrl[`CTRL_ONLINE_A];
      ledPortB <= ctrl[`CTRL_ONLINE_B];
      // A port coming online darkens the lamp in step with the port lamp
      ledTest <= (inTest || lampTest) && !ctrl[`CTRL_ONLINE_A] && !ctrl[`CTRL_ONLINE_B];
    end
  end

  // ---------------------------------------------------------------
  // Display
  // ---------------------------------------------------------------
  function automatic char_t digitChar(input logic [3:0] d);
    return `CH_ZERO + {4'h0, d};
  endfunction

  char_t next_d3;
  char_t next_d2;
  char_t next_d1;
  char_t next_d0;
  logic  blankSel;

  always_comb begin
    blankSel = editing && blinkPhase;
    next_d3 = digitChar(unitNum[15:12]);
    next_d2 = digitChar(unitNum[11:8]);
    next_d1 = digitChar(unitNum[7:4]);
    next_d0 = digitChar(unitNum[3:0]);
    if (lampTest) begin
      next_d3 = 8'hFF;
      next_d2 = 8'hFF;
      next_d1 = 8'hFF;
      next_d0 = 8'hFF;
    end else if (mode == MODE_FAULTSHOW) begin
      next_d3 = `CH_E;
      next_d2 = `CH_BLANK;
      next_d1 = digitChar(errCode[7:4]);
      next_d0 = digitChar(errCode[3:0]);
    end else if (mode == MODE_TESTNUM || mode == MODE_RUNNING) begin
      next_d3 = (mode == MODE_RUNNING && blinkPhase) ? `CH_BLANK : `CH_T;
      next_d2 = `CH_BLANK;
      next_d1 = (blankSel && digitSel[0]) ? `CH_BLANK : digitChar(testNum[7:4]);
      next_d0 = (blankSel && !digitSel[0]) ? `CH_BLANK : digitChar(testNum[3:0]);
    end else if (mode == MODE_UNIT) begin
      if (blankSel) begin
        case (digitSel)
          2'd0: next_d0 = `CH_BLANK;
          2'd1: next_d1 = `CH_BLANK;
          2'd2: next_d2 = `CH_BLANK;
          default: next_d3 = `CH_BLANK;
        endcase
      end
    end else if (!showUnit && (swLevel[3:0] != 4'h0)) begin
      next_d3 = swLevel[SW_RUN] ? `CH_R : `CH_BLANK;
      next_d2 = swLevel[SW_WP] ? `CH_W : `CH_BLANK;
      next_d1 = swLevel[SW_A] ? `CH_A : `CH_BLANK;
      next_d0 = swLevel[SW_B] ? `CH_B : `CH_BLANK;
    end
    // Otherwise the unit number stands, covering and the timed show
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      disp3 <= `CH_BLANK;
      disp2 <= `CH_BLANK;
      disp1 <= `CH_BLANK;
      disp0 <= `CH_BLANK;
      testRunning <= 1'b0;
    end else begin
      disp3 <= next_d3;
      disp2 <= next_d2;
      disp1 <= next_d1;
      disp0 <= next_d0;
      testRunning <= (mode == MODE_RUNNING) && !ctrl[`CTRL_ONLINE_A] && !ctrl[`CTRL_ONLINE_B];
    end
  end

  // ---------------------------------------------------------------
  // APB read and ready; one wait state
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= badAddr;
      prdata <= 32'h0000_0000;
      if (apbRead) begin
        case (paddr)
          `OP_CTRL_ADDR: prdata <= {23'h000000, ctrl};
          `OP_STATUS_ADDR: prdata <= {16'h0000, testRunning, lampTest, showUnit, 3'b000,
                                      mode, ledTest, ledPortB, ledPortA, ledWriteProt,
                                      ledFault, ledRun, ledReady};
          `OP_DISPLAY_ADDR: prdata <= {disp3, disp2, disp1, disp0};
          `OP_ERRCODE_ADDR: prdata <= {24'h000000, errCode};
          `OP_NUMBER_ADDR: prdata <= {8'h00, testNum, unitNum};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule

// ### testbench/operator_panel_assertions.sv
// Port-level concurrent checks for the operator panel controller
`include "operator_panel_regs.svh"
module operator_panel_assertions (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ledReady,
  input wire logic        ledRun,
  input wire logic        ledFault,
  input wire logic        ledWriteProt,
  input wire logic        ledPortA,
  input wire logic        ledPortB,
  input wire logic        ledTest,
  input wire logic        testRunning
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  logic mapped;
  logic ctrlWr;
  assign mapped = paddr inside {`OP_CTRL_ADDR, `OP_STATUS_ADDR, `OP_DISPLAY_ADDR,
                                `OP_ERRCODE_ADDR, `OP_NUMBER_ADDR};
  // Write data is still held by the master in the answer cycle
  assign ctrlWr = pready && pwrite && !pslverr && (paddr == `OP_CTRL_ADDR);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence access_s;
    psel && penable && !pready;
  endsequence
  sequence answer_s;
    pready ##1 !pready;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  apb_wait_a: assert property (access_s |=> answer_s)
    else $error("bus answer not a single cycle after one wait state");
  slverr_map_a: assert property (pready |-> (pslverr == !mapped))
    else $error("error response does not match address map");
  run_follow_a: assert property (ctrlWr |=> ##1 (ledRun == $past(pwdata[0], 2)))
    else $error("run lamp does not follow spin state");
  fault_follow_a: assert property (ctrlWr |=> ##1 (ledFault == $past(pwdata[5] && pwdata[6], 2)))
    else $error("fault lamp does not follow error and fault bits");
  wp_follow_a: assert property (ctrlWr |=> ##1 (ledWriteProt == $past(pwdata[7] || pwdata[8], 2)))
    else $error("write protect lamp wrong");
  port_follow_a: assert property (ctrlWr |=> ##1 ({ledPortB, ledPortA} == $past(pwdata[3:2], 2)))
    else $error("port lamps do not follow online state");
  ready_rise_a: assert property ($rose(ledReady) |-> ledRun)
    else $error("ready lamp lit without run lamp");
  test_ports_a: assert property (ledTest |-> !ledPortA && !ledPortB)
    else $error("test lamp lit with a port lamp");
  run_in_test_a: assert property (testRunning |-> ledTest)
    else $error("test running outside test mode");
endmodule
bind operator_panel operator_panel_assertions operator_panel_assertions_i (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .ledReady(ledReady), .ledRun(ledRun), .ledFault(ledFault), .ledWriteProt(ledWriteProt),
  .ledPortA(ledPortA), .ledPortB(ledPortB), .ledTest(ledTest), .testRunning(testRunning)
);

// ### testbench/operator_panel_tb.sv
// Self-checking bench for the operator panel controller
`include "operator_panel_regs.svh"
module operator_panel_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import operator_panel_pkg::*;
  // ----------------------------------------
  // Signals and design
  // ----------------------------------------
  localparam int SHOW = 40;
  localparam int LIMIT = 20000;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, testRunning;
  logic [5:0]  switchIn = 6'h00;
  logic        ledReady, ledRun, ledFault, ledWriteProt, ledPortA, ledPortB, ledTest;
  char_t       disp3, disp2, disp1, disp0;
  logic [31:0] disp;
  logic [5:0]  leds;
  int          failCount = 0;
  int          testsRun = 0;
  int          cycles = 0;
  logic [8:0]  ctrlTab [10] = '{9'h001, 9'h003, 9'h015, 9'h00D, 9'h012,
                                9'h020, 9'h060, 9'h040, 9'h080, 9'h100};
  assign disp = {disp3, disp2, disp1, disp0};
  assign leds = {ledReady, ledRun, ledFault, ledWriteProt, ledPortA, ledPortB};
  operator_panel #(.SHOW_CYCLES(SHOW), .BLINK_CYCLES(8), .DEBOUNCE_CYCLES(3)) operator_panel_i (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .switchIn(switchIn), .ledReady(ledReady), .ledRun(ledRun), .ledFault(ledFault),
    .ledWriteProt(ledWriteProt), .ledPortA(ledPortA), .ledPortB(ledPortB),
    .ledTest(ledTest), .disp3(disp3), .disp2(disp2), .disp1(disp1), .disp0(disp0),
    .testRunning(testRunning));
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failCount++;
      final_report();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    testsRun++;
    if (seen !== expd) begin
      failCount++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask
  // Holds the request until pready is seen high, then idles one cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    check(r & m, x);
  endtask
  // Long enough for synchroniser plus debounce on both edges
  task automatic press(input int b, input int n);
    repeat (n) begin
      switchIn[b] <= 1'b1;
      repeat (12) @(posedge clk);
      switchIn[b] <= 1'b0;
      repeat (12) @(posedge clk);
    end
  endtask
  function automatic logic [5:0] ledExp(input logic [8:0] c);
    ledExp = {c[0] & (c[1] | ((c[2] | c[3]) & c[4])), c[0], c[5] & c[6], c[7] | c[8], c[2], c[3]};
  endfunction
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin : main
    logic [31:0] r;
    logic        e;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    check(disp, 32'h30303030);
    check(leds, 32'h0);
    rdchk(`OP_CTRL_ADDR, 32'hFFFFFFFF, 32'h0);
    wr(`OP_CTRL_ADDR, 32'h1FF);
    rdchk(`OP_CTRL_ADDR, 32'h1FF, 32'h1FF);
    apb(1'b0, 12'h020, 32'h0, r, e);
    check(r, 32'h0);
    check({31'h0, e}, 32'h1);
    $display("registers done");
    for (int i = 0; i < 10; i++) begin
      wr(`OP_CTRL_ADDR, ctrlTab[i]);
      repeat (3) @(posedge clk);
      check(leds, ledExp(ctrlTab[i]));
    end
    wr(`OP_CTRL_ADDR, 32'h0);
    $display("lamps done");
    switchIn <= 6'h0F;
    repeat (14) @(posedge clk);
    check(disp, 32'h52574142);
    switchIn <= 6'h0A;
    repeat (14) @(posedge clk);
    check(disp, 32'h20572042);
    switchIn <= 6'h00;
    repeat (14) @(posedge clk);
    check(disp, 32'h30303030);
    $display("switch view done");
    press(4, 1);
    check(ledTest, 1'b1);
    check(disp, 32'h30303030);
    press(2, 1);
    r = {24'h00, disp0};
    repeat (8) @(posedge clk);
    check(r[7:0] ^ disp0, 8'h10);
    press(3, 9);
    rdchk(`OP_NUMBER_ADDR, 32'hFFFF, 32'h0009);
    press(3, 1);
    rdchk(`OP_NUMBER_ADDR, 32'hFFFF, 32'h0000);
    press(2, 3);
    press(3, 5);
    rdchk(`OP_NUMBER_ADDR, 32'hFFFF, 32'h0000);
    press(3, 4);
    press(2, 3);
    press(3, 9);
    rdchk(`OP_NUMBER_ADDR, 32'hFFFF, 32'h4900);
    press(1, 1);
    check({disp3, disp2}, 16'h5420);
    rdchk(`OP_NUMBER_ADDR, 32'hFF0000, 32'h0);
    press(1, 1);
    check(testRunning, 1'b1);
    r = {24'h00, disp3};
    repeat (8) @(posedge clk);
    check(r[7:0] ^ disp3, 8'h74);
    press(2, 1);
    check({testRunning, ledTest}, 2'b01);
    press(1, 1);
    check(testRunning, 1'b1);
    press(1, 1);
    check({testRunning, ledTest}, 2'b01);
    press(4, 1);
    check({testRunning, ledTest}, 2'b00);
    rdchk(`OP_NUMBER_ADDR, 32'hFFFF, 32'h4094);
    check(disp, 32'h34303934);
    $display("test mode done");
    wr(`OP_CTRL_ADDR, 32'h004);
    press(4, 1);
    check(ledTest, 1'b0);
    rdchk(`OP_STATUS_ADDR, 32'h2000, 32'h2000);
    repeat (SHOW + 10) @(posedge clk);
    rdchk(`OP_STATUS_ADDR, 32'h2000, 32'h0);
    $display("unit show done");
    wr(`OP_ERRCODE_ADDR, 32'h37);
    wr(`OP_CTRL_ADDR, 32'h060);
    press(5, 1);
    check(disp, 32'h45203337);
    press(5, 1);
    check(disp, 32'h34303934);
    wr(`OP_CTRL_ADDR, 32'h0);
    press(5, 1);
    check(disp0, 8'hFF);
    rdchk(`OP_STATUS_ADDR, 32'h4000, 32'h4000);
    repeat (SHOW + 10) @(posedge clk);
    check(disp, 32'h34303934);
    wr(`OP_STATUS_ADDR, 32'hFFFFFFFF);
    repeat (3) @(posedge clk);
    check(leds, 32'h0);
    $display("fault and lamp test done");
    final_report();
  end
endmodule
